// ---- hw/tsr_defs.svh ----
// Named constants for the timing signal router
`ifndef TSR_DEFS_SVH
`define TSR_DEFS_SVH
`define TSR_ADDR_W 4
`define TSR_OFF_TICK_SEL 4'h0
`define TSR_OFF_ACQ_SEL 4'h1
`define TSR_OFF_SCAN_SEL 4'h2
`define TSR_OFF_SAMP_SEL 4'h3
`define TSR_OFF_OUT_SEL 4'h4
`define TSR_OFF_UPD_SEL 4'h5
`define TSR_OFF_POLARITY 4'h6
`define TSR_OFF_SW_TRIG 4'h7
`define TSR_OFF_STATUS 4'h8
`define TSR_OFF_COUNT 4'h9
`define TSR_BIT_SW_ACQ 0
`define TSR_BIT_SW_OUT 1
`define TSR_BIT_POL_ACQ 0
`define TSR_BIT_POL_OUT 1
`define TSR_SEL_RESET 2'h0
`define TSR_POL_RESET 2'h0
`define TSR_UNMAPPED_DATA 32'h0000_0000
`define TSR_INT_OSC_HZ 40000000
`define TSR_EXT_TICK_MIN_HZ 1000000
`define TSR_EXT_TICK_MAX_HZ 40000000
`define TSR_AUX0_SCAN_MIN_TICKS 2
`endif

// ---- hw/tsr_edge_if.sv ----
// Interface carrying one edge detector's input and its rise and fall pulses
`timescale 1ns/100ps
interface tsr_edge_if;
  logic level;
  logic riseEdge;
  logic fallEdge;
  modport detector (input level, output riseEdge, output fallEdge);
  modport user (output level, input riseEdge, input fallEdge);
endinterface

// ---- hw/tsr_edge_sync.sv ----
// Two-stage synchroniser with edge detection on the tick enable
`timescale 1ns/100ps
module tsr_edge_sync (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic tickEn,
  tsr_edge_if.detector port
);
  logic stage1_reg;
  logic stage2_reg;
  logic last_reg;
  logic rise_reg;
  logic fall_reg;

  // First stage feeds only the second; edges come from stage two
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      stage1_reg <= 1'b0;
      stage2_reg <= 1'b0;
      last_reg <= 1'b0;
      rise_reg <= 1'b0;
      fall_reg <= 1'b0;
    end else begin
      rise_reg <= 1'b0;
      fall_reg <= 1'b0;
      if (tickEn) begin
        stage1_reg <= port.level;
        stage2_reg <= stage1_reg;
        last_reg <= stage2_reg;
        rise_reg <= stage2_reg & ~last_reg;
        fall_reg <= ~stage2_reg & last_reg;
      end
    end
  end

  assign port.riseEdge = rise_reg;
  assign port.fallEdge = fall_reg;
endmodule

// ---- hw/tsr_pkg.sv ----
// Types for the timing signal router
package tsr_pkg;
  typedef enum logic [1:0] {
    TSR_TICK_INTERNAL,
    TSR_TICK_EXTERNAL,
    TSR_TICK_SYNC
  } tsr_tick_src_type;
  typedef enum logic [1:0] {
    TSR_TRIG_EXTPIN,
    TSR_TRIG_ANALOG,
    TSR_TRIG_SOFTWARE,
    TSR_TRIG_SYNC
  } tsr_trig_src_type;
  typedef enum logic [1:0] {
    TSR_STROBE_INTERNAL,
    TSR_STROBE_AUX,
    TSR_STROBE_SYNC
  } tsr_strobe_src_type;
endpackage

// ---- hw/tsr_timing_router.sv ----
// Timing signal router: tick, triggers and strobes with bus registers
`timescale 1ns/100ps
`include "tsr_defs.svh"

module tsr_timing_router
  import tsr_pkg::*;
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic [`TSR_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic intOscTick,
  input wire logic external_tick_input,
  input wire logic sync_link_tick,
  input wire logic ext_acq_trigger_pin,
  input wire logic ext_output_trigger_pin,
  input wire logic analogTrigger,
  input wire logic aux_input_zero,
  input wire logic aux_input_one,
  input wire logic sync_link_acq_trigger,
  input wire logic sync_link_output_trigger,
  input wire logic sync_link_scan_begin,
  input wire logic sync_link_sample_strobe,
  input wire logic sync_link_update_strobe,
  input wire logic scanIntervalPulse,
  input wire logic sampleCounterPulse,
  input wire logic updateCounterPulse,
  output logic masterTick,
  output logic acq_trigger,
  output logic output_trigger,
  output logic scan_begin,
  output logic sample_strobe,
  output logic output_update_strobe
);
  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  tsr_tick_src_type tickSel_reg;
  tsr_trig_src_type acqSel_reg;
  tsr_trig_src_type outSel_reg;
  tsr_strobe_src_type scanSel_reg;
  tsr_strobe_src_type sampSel_reg;
  tsr_strobe_src_type updSel_reg;
  logic [1:0] polarity_reg;
  logic swAcq_reg;
  logic swOut_reg;
  logic [15:0] sampleCount_reg;
  logic ackPending_reg;
  logic tickLevel_reg;
  logic tickLast_reg;
  logic tickEn;

  // ----------------------------------------------------------------
  // Master tick selection and enable
  // ----------------------------------------------------------------
  // Selected tick is sampled and turned into one enable per rising edge;
  // sources faster than half clk_sys are therefore not resolved.
  wire tickSelLevel = (tickSel_reg == TSR_TICK_EXTERNAL) ?
                      external_tick_input :
                      (tickSel_reg == TSR_TICK_SYNC) ?
                      sync_link_tick : intOscTick;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      tickLevel_reg <= 1'b0;
      tickLast_reg <= 1'b0;
    end else begin
      tickLevel_reg <= tickSelLevel;
      tickLast_reg <= tickLevel_reg;
    end
  end
  assign tickEn = tickLevel_reg & ~tickLast_reg;

  // ----------------------------------------------------------------
  // Synchronisers
  // ----------------------------------------------------------------
  localparam int NumIn = 9;
  tsr_edge_if edges[NumIn] ();
  assign edges[0].level = ext_acq_trigger_pin;
  assign edges[1].level = ext_output_trigger_pin;
  assign edges[2].level = aux_input_zero;
  assign edges[3].level = aux_input_one;
  assign edges[4].level = sync_link_acq_trigger;
  assign edges[5].level = sync_link_output_trigger;
  assign edges[6].level = sync_link_scan_begin;
  assign edges[7].level = sync_link_sample_strobe;
  assign edges[8].level = sync_link_update_strobe;
  genvar g;
  generate
    for (g = 0; g < NumIn; g++) begin : gSync
      tsr_edge_sync uSync (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .tickEn(tickEn),
        .port(edges[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Source multiplexers
  // ----------------------------------------------------------------
  function automatic logic pickTrig(input tsr_trig_src_type sel,
                                    input logic pin, input logic ana,
                                    input logic sw, input logic sync);
    unique case (sel)
      TSR_TRIG_EXTPIN: pickTrig = pin;
      TSR_TRIG_ANALOG: pickTrig = ana;
      TSR_TRIG_SOFTWARE: pickTrig = sw;
      TSR_TRIG_SYNC: pickTrig = sync;
    endcase
  endfunction
  function automatic logic pickStrobe(input tsr_strobe_src_type sel,
                                      input logic cnt, input logic aux,
                                      input logic sync);
    unique case (sel)
      TSR_STROBE_AUX: pickStrobe = aux;
      TSR_STROBE_SYNC: pickStrobe = sync;
      default: pickStrobe = cnt;
    endcase
  endfunction

  // Trigger pins: edge chosen per path by polarity bit
  wire acqPinEdge = polarity_reg[`TSR_BIT_POL_ACQ] ? edges[0].fallEdge :
                    edges[0].riseEdge;
  wire outPinEdge = polarity_reg[`TSR_BIT_POL_OUT] ? edges[1].fallEdge :
                    edges[1].riseEdge;
  wire auxZeroStrobe = (sampSel_reg == TSR_STROBE_AUX);
  // Aux zero feeds scan begin only when not claimed as sample strobe
  wire auxZeroScan = (scanSel_reg == TSR_STROBE_AUX) &&
                     !auxZeroStrobe;
  wire acqTrigNext = auxZeroStrobe ? 1'b0 :
                     pickTrig(acqSel_reg, acqPinEdge, analogTrigger,
                              swAcq_reg, edges[4].riseEdge);
  wire outTrigNext = pickTrig(outSel_reg, outPinEdge, analogTrigger,
                              swOut_reg, edges[5].riseEdge);
  wire scanNext = auxZeroStrobe ? 1'b0 :
                  auxZeroScan ? edges[2].riseEdge :
                  (scanSel_reg == TSR_STROBE_SYNC) ? edges[6].riseEdge :
                  (tickEn & scanIntervalPulse);
  wire sampNext = pickStrobe(sampSel_reg, tickEn & sampleCounterPulse,
                             edges[2].riseEdge,
                             edges[7].riseEdge);
  wire updNext = pickStrobe(updSel_reg, tickEn & updateCounterPulse,
                            edges[3].riseEdge,
                            edges[8].riseEdge);

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      masterTick <= 1'b0;
      acq_trigger <= 1'b0;
      output_trigger <= 1'b0;
      scan_begin <= 1'b0;
      sample_strobe <= 1'b0;
      output_update_strobe <= 1'b0;
    end else begin
      masterTick <= tickEn;
      acq_trigger <= acqTrigNext;
      output_trigger <= outTrigNext;
      scan_begin <= scanNext;
      sample_strobe <= sampNext;
      output_update_strobe <= updNext;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sampleCount_reg <= 16'h0000;
    end else if (sampNext) begin
      sampleCount_reg <= sampleCount_reg + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // Avalon-MM slave: one wait cycle, then answer
  // ----------------------------------------------------------------
  wire access = (avs_read | avs_write) & ~ackPending_reg;
  wire wrHit = avs_write & ~ackPending_reg;
  wire [31:0] readMux =
    (avs_address == `TSR_OFF_TICK_SEL) ? {30'h0, tickSel_reg} :
    (avs_address == `TSR_OFF_ACQ_SEL) ? {30'h0, acqSel_reg} :
    (avs_address == `TSR_OFF_SCAN_SEL) ? {30'h0, scanSel_reg} :
    (avs_address == `TSR_OFF_SAMP_SEL) ? {30'h0, sampSel_reg} :
    (avs_address == `TSR_OFF_OUT_SEL) ? {30'h0, outSel_reg} :
    (avs_address == `TSR_OFF_UPD_SEL) ? {30'h0, updSel_reg} :
    (avs_address == `TSR_OFF_POLARITY) ? {30'h0, polarity_reg} :
    (avs_address == `TSR_OFF_STATUS) ?
      {29'h0, auxZeroScan, auxZeroStrobe, tickLevel_reg} :
    (avs_address == `TSR_OFF_COUNT) ? {16'h0, sampleCount_reg} :
    `TSR_UNMAPPED_DATA;
  // A strobe selector code of 3 is illegal and falls back to internal
  function automatic tsr_strobe_src_type toStrobe(input logic [1:0] v);
    toStrobe = (v == 2'h3) ? TSR_STROBE_INTERNAL : tsr_strobe_src_type'(v);
  endfunction
  // Aux zero may hold only one role; a write claiming the second is refused
  wire sampWriteOk = !(toStrobe(avs_writedata[1:0]) == TSR_STROBE_AUX &&
                       scanSel_reg == TSR_STROBE_AUX);
  wire scanWriteOk = !(toStrobe(avs_writedata[1:0]) == TSR_STROBE_AUX &&
                       sampSel_reg == TSR_STROBE_AUX);

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ackPending_reg <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
    end else begin
      ackPending_reg <= access;
      avs_waitrequest <= ~access;
      if (access) begin
        avs_readdata <= readMux;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      tickSel_reg <= TSR_TICK_INTERNAL;
      acqSel_reg <= TSR_TRIG_SOFTWARE;
      outSel_reg <= TSR_TRIG_SOFTWARE;
      scanSel_reg <= TSR_STROBE_INTERNAL;
      sampSel_reg <= TSR_STROBE_INTERNAL;
      updSel_reg <= TSR_STROBE_INTERNAL;
      polarity_reg <= `TSR_POL_RESET;
      swAcq_reg <= 1'b0;
      swOut_reg <= 1'b0;
    end else begin
      // Software trigger lasts one cycle
      swAcq_reg <= wrHit && avs_address == `TSR_OFF_SW_TRIG &&
                   avs_writedata[`TSR_BIT_SW_ACQ];
      swOut_reg <= wrHit && avs_address == `TSR_OFF_SW_TRIG &&
                   avs_writedata[`TSR_BIT_SW_OUT];
      if (wrHit) begin
        unique case (avs_address)
          `TSR_OFF_TICK_SEL:
            tickSel_reg <= (avs_writedata[1:0] == 2'h3) ? TSR_TICK_INTERNAL :
                           tsr_tick_src_type'(avs_writedata[1:0]);
          `TSR_OFF_ACQ_SEL:
            acqSel_reg <= tsr_trig_src_type'(avs_writedata[1:0]);
          `TSR_OFF_OUT_SEL:
            outSel_reg <= tsr_trig_src_type'(avs_writedata[1:0]);
          `TSR_OFF_SCAN_SEL:
            if (scanWriteOk) scanSel_reg <= toStrobe(avs_writedata[1:0]);
          `TSR_OFF_SAMP_SEL:
            if (sampWriteOk) sampSel_reg <= toStrobe(avs_writedata[1:0]);
          `TSR_OFF_UPD_SEL:
            updSel_reg <= toStrobe(avs_writedata[1:0]);
          `TSR_OFF_POLARITY:
            polarity_reg <= avs_writedata[1:0];
          default: ;
        endcase
      end
    end
  end
endmodule

// ---- sim/tsr_far_side.sv ----
// Far-side model: external tick, trigger pins, aux and sync lines
`timescale 1ns/100ps
module tsr_far_side (
  input wire logic clk_sys,
  output logic external_tick_input,
  output logic [8:0] lines
);
  // ----------------
  // Tick and lines
  // ----------------
  logic [1:0] divReg = 2'h0;
  initial external_tick_input = 1'b0;
  initial lines = 9'h000;
  // Period of 8 clocks, 6.25 MHz, well inside the legal band
  always @(posedge clk_sys) begin
    divReg <= divReg + 2'h1;
    if (divReg == 2'h3) begin
      external_tick_input <= !external_tick_input;
    end
  end
  // Held 24 clocks: over two periods of the slowest tick in use
  task pulse(input int idx);
    @(posedge clk_sys);
    lines[idx] <= 1'b1;
    repeat (24) @(posedge clk_sys);
    lines[idx] <= 1'b0;
    repeat (24) @(posedge clk_sys);
  endtask
endmodule

// ---- sim/tsr_timing_router_bench.sv ----
// Self-checking bench for the timing signal router
`timescale 1ns/100ps
`include "tsr_defs.svh"
module tsr_timing_router_bench import tsr_pkg::*;;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic intOscTick = 1'b0;
  logic sampleCounterPulse = 1'b0;
  logic scanIntervalPulse = 1'b0;
  logic updateCounterPulse = 1'b0;
  logic analogTrigger = 1'b0;
  logic [1:0] syncDiv = 2'h0;
  logic [3:0] avs_address = 4'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, rd;
  logic avs_waitrequest, extTick, masterTick, acq_trigger, output_trigger;
  logic scan_begin, sample_strobe, output_update_strobe;
  logic [8:0] fl;
  logic [5:0] evt;
  logic [15:0] cnt;
  int seen [6] = '{0, 0, 0, 0, 0, 0};
  int base [6];
  int failCount = 0;
  int nChecks = 0;
  always #10 clk_sys = !clk_sys;
  always @(posedge clk_sys) intOscTick <= !intOscTick;
  // Sync tick runs at a quarter of clk_sys, apart from both other sources
  always @(posedge clk_sys) syncDiv <= syncDiv + 2'h1;
  assign evt = {output_update_strobe, sample_strobe, scan_begin,
    output_trigger, acq_trigger, masterTick};
  always @(posedge clk_sys) begin
    for (int i = 0; i < 6; i++) if (evt[i] === 1'b1) seen[i]++;
  end
  tsr_far_side u_tsr_far_side (.clk_sys, .external_tick_input(extTick),
    .lines(fl));
  tsr_timing_router u_tsr_timing_router (.clk_sys, .arst_n, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
    .intOscTick, .external_tick_input(extTick), .sync_link_tick(syncDiv[1]),
    .ext_acq_trigger_pin(fl[0]), .ext_output_trigger_pin(fl[1]),
    .analogTrigger, .aux_input_zero(fl[2]), .aux_input_one(fl[3]),
    .sync_link_acq_trigger(fl[4]), .sync_link_output_trigger(fl[5]),
    .sync_link_scan_begin(fl[6]), .sync_link_sample_strobe(fl[7]),
    .sync_link_update_strobe(fl[8]), .scanIntervalPulse,
    .sampleCounterPulse, .updateCounterPulse, .masterTick,
    .acq_trigger, .output_trigger, .scan_begin, .sample_strobe,
    .output_update_strobe);
  // ----------
  // Tasks
  // ----------
  task print_verdict;
    $display("checks %0d mismatches %0d", nChecks, failCount);
    if (failCount == 0 && nChecks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task check(input string what, input logic [31:0] got, exp);
    nChecks++;
    if (got !== exp) begin
      failCount++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task rdchk(input string w, input logic [3:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check(w, rd, e);
  endtask
  task ev(input string w, input int i, input int n);
    repeat (16) @(posedge clk_sys);
    check(w, seen[i] - base[i], n);
  endtask
  // Acq and output trigger sources together; -1 software, -2 analog
  task trig(input logic [31:0] code, input int ia, input int io);
    bus(1'b1, `TSR_OFF_ACQ_SEL, code);
    bus(1'b1, `TSR_OFF_OUT_SEL, code);
    base = seen;
    if (ia >= 0) begin
      u_tsr_far_side.pulse(ia);
      u_tsr_far_side.pulse(io);
    end else if (ia == -2) begin
      @(posedge clk_sys);
      analogTrigger <= 1'b1;
      @(posedge clk_sys);
      analogTrigger <= 1'b0;
    end else bus(1'b1, `TSR_OFF_SW_TRIG, 32'h3);
    ev("acq trigger", 1, 1);
    ev("output trigger", 2, 1);
  endtask
  // ----------
  // Tests
  // ----------
  initial begin
    repeat (2) @(posedge clk_sys);
    arst_n <= 1'b1;
    rdchk("tick sel", `TSR_OFF_TICK_SEL, 32'h0);
    rdchk("acq sel", `TSR_OFF_ACQ_SEL, 32'h2);
    rdchk("out sel", `TSR_OFF_OUT_SEL, 32'h2);
    rdchk("scan sel", `TSR_OFF_SCAN_SEL, 32'h0);
    rdchk("sample sel", `TSR_OFF_SAMP_SEL, 32'h0);
    rdchk("update sel", `TSR_OFF_UPD_SEL, 32'h0);
    rdchk("unmapped", 4'hf, `TSR_UNMAPPED_DATA);
    bus(1'b1, `TSR_OFF_SAMP_SEL, 32'h1);
    bus(1'b1, `TSR_OFF_SCAN_SEL, 32'h1);
    rdchk("scan second role", `TSR_OFF_SCAN_SEL, 32'h0);
    bus(1'b0, `TSR_OFF_STATUS, 32'h0);
    check("aux zero roles", {30'h0, rd[2:1]}, 32'h1);
    bus(1'b0, `TSR_OFF_COUNT, 32'h0);
    cnt = rd[15:0];
    base = seen;
    u_tsr_far_side.pulse(2);
    sampleCounterPulse <= 1'b1;
    scanIntervalPulse <= 1'b1;
    repeat (2) @(posedge clk_sys);
    sampleCounterPulse <= 1'b0;
    scanIntervalPulse <= 1'b0;
    bus(1'b1, `TSR_OFF_SW_TRIG, 32'h1);
    repeat (2) u_tsr_far_side.pulse(2);
    ev("aux zero strobes", 4, 3);
    check("acq in aux mode", seen[1] - base[1], 0);
    check("scan in aux mode", seen[3] - base[3], 0);
    bus(1'b0, `TSR_OFF_COUNT, 32'h0);
    check("sample count", {16'h0, rd[15:0] - cnt}, 32'h3);
    bus(1'b1, `TSR_OFF_SAMP_SEL, 32'h0);
    base = seen;
    sampleCounterPulse <= 1'b1;
    scanIntervalPulse <= 1'b1;
    updateCounterPulse <= 1'b1;
    repeat (2) @(posedge clk_sys);
    sampleCounterPulse <= 1'b0;
    scanIntervalPulse <= 1'b0;
    updateCounterPulse <= 1'b0;
    ev("counter strobe", 4, 1);
    check("counter scan", seen[3] - base[3], 1);
    check("counter update", seen[5] - base[5], 1);
    bus(1'b1, `TSR_OFF_SAMP_SEL, 32'h2);
    base = seen;
    u_tsr_far_side.pulse(7);
    ev("sync strobe", 4, 1);
    bus(1'b1, `TSR_OFF_SAMP_SEL, 32'h0);
    for (int s = 1; s < 3; s++) begin
      bus(1'b1, `TSR_OFF_SCAN_SEL, s);
      base = seen;
      u_tsr_far_side.pulse(s == 1 ? 2 : 6);
      ev("scan begin", 3, 1);
    end
    bus(1'b1, `TSR_OFF_SCAN_SEL, 32'h0);
    bus(1'b1, `TSR_OFF_UPD_SEL, 32'h2);
    base = seen;
    u_tsr_far_side.pulse(8);
    ev("sync update", 5, 1);
    for (int p = 0; p < 2; p++) begin
      bus(1'b1, `TSR_OFF_POLARITY, {30'h0, p[0], p[0]});
      trig(32'h0, 0, 1);
    end
    trig(32'h3, 4, 5);
    trig(32'h2, -1, -1);
    trig(32'h1, -2, -2);
    bus(1'b1, `TSR_OFF_UPD_SEL, 32'h1);
    bus(1'b1, `TSR_OFF_TICK_SEL, 32'h1);
    repeat (16) @(posedge clk_sys);
    base = seen;
    repeat (80) @(posedge clk_sys);
    check("external ticks", seen[0] - base[0], 10);
    base = seen;
    repeat (2) u_tsr_far_side.pulse(3);
    ev("aux one updates", 5, 2);
    for (int t = 0; t < 3; t += 2) begin
      bus(1'b1, `TSR_OFF_TICK_SEL, t);
      repeat (16) @(posedge clk_sys);
      base = seen;
      repeat (80) @(posedge clk_sys);
      check("ticks", seen[0] - base[0], t == 0 ? 40 : 20);
    end
    print_verdict;
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    failCount++;
    print_verdict;
  end
endmodule

// ---- sim/tsr_timing_router_checker.sv ----
// Port properties of the timing signal router
`timescale 1ns/100ps
module tsr_timing_router_checker (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic aux_input_zero,
  input wire logic masterTick,
  input wire logic acq_trigger,
  input wire logic output_trigger,
  input wire logic scan_begin,
  input wire logic sample_strobe,
  input wire logic output_update_strobe
);
  // ----------
  // Properties
  // ----------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  a_answer_bound: assert property ((avs_read || avs_write) &&
    avs_waitrequest |-> ##[1:2] !avs_waitrequest) else $error("late answer");
  a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("answer too long");
  a_reset_quiet:
    assert property ($rose(arst_n) |-> avs_waitrequest && !sample_strobe &&
      !masterTick) else $error("busy after reset");
  a_tick_single:
    assert property (masterTick |=> !masterTick) else $error("tick long");
  a_sample_single:
    assert property (sample_strobe |=> !sample_strobe)
      else $error("sample strobe long");
  a_update_single:
    assert property (output_update_strobe |=> !output_update_strobe)
      else $error("update strobe long");
  a_acq_single:
    assert property (acq_trigger |-> ##1 !acq_trigger)
      else $error("acq trigger long");
  a_out_single:
    assert property ($rose(output_trigger) |=> $fell(output_trigger))
      else $error("output trigger long");
  a_scan_single:
    assert property (scan_begin |=> !scan_begin) else $error("scan long");
  a_aux_sync:
    assert property ($rose(aux_input_zero) |-> !sample_strobe[*3])
      else $error("aux strobe skipped synchroniser");
  c_sample: cover property (sample_strobe);
  c_update: cover property (output_update_strobe);
  c_scan: cover property (scan_begin);
endmodule
bind tsr_timing_router tsr_timing_router_checker u_tsr_timing_router_checker (
  .clk_sys(clk_sys), .arst_n(arst_n), .avs_read(avs_read),
  .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
  .aux_input_zero(aux_input_zero), .masterTick(masterTick),
  .acq_trigger(acq_trigger), .output_trigger(output_trigger),
  .scan_begin(scan_begin), .sample_strobe(sample_strobe),
  .output_update_strobe(output_update_strobe));
